// *** hdl/ndm_top.sv ***
// sequence directional element plus four-zone phase mho distance logic
// assumes the front end presents a full phasor set with a one-cycle update strobe
`timescale 1ns/100ps

// Notes on behaviour
// - sequence V and I from phase A plus rotated B and C, kept at three times the value
// - directional impedance is Re(V2 conj(I2 at line angle)) over |I2| squared
// - reverse flag set while impedance exceeds reverse threshold, dropped below it
// - forward flag only while impedance lies below forward threshold, or while potential loss forces it
// - positive reverse setting: threshold 0.75 setting plus 0.25 measured ratio
// - positive forward setting: threshold 1.25 setting minus 0.25 measured ratio
// - flags need 3*I2 above pickup and I2 above ratio times I1
// - any element flag may be routed to contact seven or eight
// - up to four zones, count setting disables the rest
// - each zone has its own reach and forward or reverse direction
// - mho maximum reach angle equals the line angle setting
// - zone flag rises at once when any phase pair is inside
// - zones two to four also give time-delayed flags
// - every phase pair in every zone has its own flag
// - potential loss with Y or Y2 forces the forward flag
// - positive-sequence current times ratio compared with sequence current
module ndm_top
   import ndm_pkg::*;
(
   input  wire logic                        mclk,
   input  wire logic                        sys_rst,
   input  wire logic                        phUpdValid,
   input  wire ndm_phasors_type             phasors,
   input  wire ndm_dir_set_type             dirSet,
   input  wire ndm_zone_cfg_type [ZONES-1:0] zoneCfg,
   input  wire logic [2:0]                  phaseZoneCount,
   input  wire ndm_lop_type                 potentialLossEnable,
   input  wire logic                        potentialLoss,
   input  wire logic [ROUTE_W-1:0]          contactSevenSrc,
   input  wire logic [ROUTE_W-1:0]          contactEightSrc,
   output logic                             fwdDirFlag,
   output logic                             revDirFlag,
   output logic [ZONES-1:0]                 zoneInstFlag,
   output logic [ZONES-2:0]                 zoneDelayedFlag,
   output logic [ZONES*PAIRS-1:0]           pairZoneFlag,
   output logic                             contactSeven,
   output logic                             contactEight
);

   // ------------------------------------------------------------
   // directional element
   // ------------------------------------------------------------
   ndm_cplx_type         v2, i2, i1;
   logic signed [WW-1:0] dirLhs, i2Sq, viMag, revRhs, fwdRhs, i2Mag;
   logic                 revHit, fwdHit, revOk, fwdOk, lopForce, fwdD, revD;

   always_comb begin
      v2 = seq3(phasors.va, phasors.vb, phasors.vc, 1'b1);
      i2 = seq3(phasors.ia, phasors.ib, phasors.ic, 1'b1);
      i1 = seq3(phasors.ia, phasors.ib, phasors.ic, 1'b0);
      i2Sq  = sq(i2);
      i2Mag = mag(i2);
      // scaled by 4 for the quarter weights and by 2^8 for Q8 settings
      dirLhs = dirNum(v2, i2, dirSet.lineCos, dirSet.lineSin) <<< (QTR_SHIFT + Z_FRAC);
      viMag  = (mag(v2) * i2Mag) <<< Z_FRAC;
      if (dirSet.revImpedanceSetting > 0) begin
         revRhs = REV_SET_QTR * WW'(dirSet.revImpedanceSetting) * i2Sq + viMag;
      end else begin
         revRhs = (WW'(dirSet.revImpedanceSetting) * i2Sq) <<< QTR_SHIFT;
      end
      if (dirSet.fwdImpedanceSetting > 0) begin
         fwdRhs = FWD_SET_QTR * WW'(dirSet.fwdImpedanceSetting) * i2Sq - viMag;
      end else begin
         fwdRhs = (WW'(dirSet.fwdImpedanceSetting) * i2Sq) <<< QTR_SHIFT;
      end
      // a zero current gives no impedance, so neither side may claim it
      revHit = (i2Sq != 0) && (dirLhs > revRhs);
      fwdHit = (i2Sq != 0) && (dirLhs < fwdRhs);
      revOk  = (i2Mag > WW'(dirSet.revSeqCurrentPickup)) &&
               ((i2Mag <<< Z_FRAC) > WW'(dirSet.seqRatioFactor) * mag(i1));
      fwdOk  = (i2Mag > WW'(dirSet.fwdSeqCurrentPickup)) &&
               ((i2Mag <<< Z_FRAC) > WW'(dirSet.seqRatioFactor) * mag(i1));
      lopForce = potentialLoss &&
                 ((potentialLossEnable == LOP_Y) || (potentialLossEnable == LOP_Y2));
      fwdD = (fwdHit && fwdOk) || lopForce;
      revD = revHit && revOk;
   end

   // ------------------------------------------------------------
   // phase mho zones
   // ------------------------------------------------------------
   ndm_cplx_type               vPair [PAIRS];
   ndm_cplx_type               iPair [PAIRS];
   logic [ZONES*PAIRS-1:0]     pairD;
   logic [ZONES-1:0]           instD;
   logic signed [WW-1:0]       reachProd;

   always_comb begin
      vPair[0] = '{re: phasors.va.re - phasors.vb.re, im: phasors.va.im - phasors.vb.im};
      vPair[1] = '{re: phasors.vb.re - phasors.vc.re, im: phasors.vb.im - phasors.vc.im};
      vPair[2] = '{re: phasors.vc.re - phasors.va.re, im: phasors.vc.im - phasors.va.im};
      iPair[0] = '{re: phasors.ia.re - phasors.ib.re, im: phasors.ia.im - phasors.ib.im};
      iPair[1] = '{re: phasors.ib.re - phasors.ic.re, im: phasors.ib.im - phasors.ic.im};
      iPair[2] = '{re: phasors.ic.re - phasors.ia.re, im: phasors.ic.im - phasors.ia.im};
      pairD     = '0;
      reachProd = '0;
      for (int z = 0; z < ZONES; z++) begin
         for (int p = 0; p < PAIRS; p++) begin
            // inside the circle through origin and reach at line angle
            reachProd = dirNum(vPair[p], iPair[p], dirSet.lineCos, dirSet.lineSin) *
                        WW'(zoneCfg[z].reach);
            if (zoneCfg[z].reverse) begin
               reachProd = -reachProd;
            end
            pairD[z*PAIRS+p] = (z < int'(phaseZoneCount)) &&
                               (reachProd > (sq(vPair[p]) <<< Z_FRAC)) &&
                               (zoneCfg[z].reverse ? revD : fwdD);
         end
         instD[z] = |pairD[z*PAIRS +: PAIRS];
      end
   end

   // ------------------------------------------------------------
   // delayed zone timers and contact routing
   // ------------------------------------------------------------
   logic [DLY_W-1:0]     dlyCnt_q [ZONES-1];
   logic [DLY_W-1:0]     dlyCnt_d [ZONES-1];
   logic [ZONES-2:0]     dly_d;
   logic [FLAG_NUM-1:0]  flagVec;
   logic                 contactSeven_d, contactEight_d;
   logic                 fwdDirFlag_d, revDirFlag_d;
   logic [ZONES-1:0]     zoneInstFlag_d;
   logic [ZONES*PAIRS-1:0] pairZoneFlag_d;

   always_comb begin
      for (int z = 0; z < ZONES - 1; z++) begin
         // saturates at the setting, so a held fault never wraps the timer
         if (!zoneInstFlag[z+1]) begin
            dlyCnt_d[z] = '0;
         end else if (dlyCnt_q[z] >= zoneCfg[z+1].delay) begin
            dlyCnt_d[z] = dlyCnt_q[z];
         end else begin
            dlyCnt_d[z] = dlyCnt_q[z] + 16'h0001;
         end
         dly_d[z] = zoneInstFlag[z+1] && (dlyCnt_q[z] >= zoneCfg[z+1].delay);
      end
      // direction, zone and pair flags hold between updates; the delayed flags still move with their timers
      fwdDirFlag_d   = phUpdValid ? fwdD : fwdDirFlag;
      revDirFlag_d   = phUpdValid ? revD : revDirFlag;
      zoneInstFlag_d = phUpdValid ? instD : zoneInstFlag;
      pairZoneFlag_d = phUpdValid ? pairD : pairZoneFlag;
      flagVec = {pairZoneFlag, zoneDelayedFlag, zoneInstFlag, revDirFlag, fwdDirFlag};
      contactSeven_d = (int'(contactSevenSrc) < FLAG_NUM) && flagVec[contactSevenSrc];
      contactEight_d = (int'(contactEightSrc) < FLAG_NUM) && flagVec[contactEightSrc];
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         fwdDirFlag      <= FLAG_RST;
         revDirFlag      <= FLAG_RST;
         zoneInstFlag    <= '0;
         pairZoneFlag    <= '0;
         zoneDelayedFlag <= '0;
         contactSeven    <= FLAG_RST;
         contactEight    <= FLAG_RST;
         for (int z = 0; z < ZONES - 1; z++) begin
            dlyCnt_q[z] <= '0;
         end
      end else begin
         fwdDirFlag      <= fwdDirFlag_d;
         revDirFlag      <= revDirFlag_d;
         zoneInstFlag    <= zoneInstFlag_d;
         pairZoneFlag    <= pairZoneFlag_d;
         zoneDelayedFlag <= dly_d;
         contactSeven    <= contactSeven_d;
         contactEight    <= contactEight_d;
         for (int z = 0; z < ZONES - 1; z++) begin
            dlyCnt_q[z] <= dlyCnt_d[z];
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_rev_flag_set: assert property (phUpdValid && revHit && revOk |=> revDirFlag)
      else $error("reverse flag missed");
   a_rev_flag_drop: assert property (phUpdValid && !revHit |=> !revDirFlag)
      else $error("reverse flag held below threshold");
   a_fwd_below_only: assert property (phUpdValid && !fwdHit && !lopForce |=> !fwdDirFlag)
      else $error("forward flag above threshold");
   a_pickup_gate: assert property (phUpdValid && !revOk |=> !revDirFlag)
      else $error("reverse flag without current supervision");
   a_lop_force_fwd: assert property (phUpdValid && potentialLoss &&
      potentialLossEnable inside {LOP_Y, LOP_Y2} |=> fwdDirFlag)
      else $error("potential loss did not force forward");
   a_flags_hold_idle: assert property (!phUpdValid |=>
      $stable(fwdDirFlag) && $stable(revDirFlag) && $stable(pairZoneFlag))
      else $error("flags moved without an update");
   a_zone_count_off: assert property (phUpdValid && phaseZoneCount < 3'h4 |=>
      !zoneInstFlag[3] && pairZoneFlag[11:9] == 3'h0)
      else $error("disabled zone asserted");
   a_zone_any_pair: assert property (zoneInstFlag[2] == |pairZoneFlag[8:6])
      else $error("zone flag disagrees with pair flags");
   a_contact_route: assert property (contactSevenSrc == 5'h00 |=>
      contactSeven == $past(fwdDirFlag))
      else $error("contact seven not following forward flag");
   a_fwd_flag_set: assert property (phUpdValid && fwdHit && fwdOk |=> fwdDirFlag)
      else $error("forward flag missed");
   a_zone_fwd_gate: assert property (phUpdValid && !zoneCfg[0].reverse && !fwdD |=>
      !zoneInstFlag[0])
      else $error("forward zone without forward direction");
   a_delay_drop: assert property (!zoneInstFlag[1] |=> !zoneDelayedFlag[0])
      else $error("zone two delayed flag outlived its zone flag");

   sequence s_zone2_rise;
      $rose(zoneInstFlag[1]);
   endsequence
   sequence s_zone2_held;
      zoneInstFlag[1] [*2];
   endsequence
   a_zone2_delay: assert property ((zoneCfg[1].delay == 16'h0002) throughout
      (s_zone2_rise ##1 s_zone2_held) |=> zoneDelayedFlag[0])
      else $error("zone two delayed flag late");

endmodule // ndm_top

// *** pkg/ndm_pkg.sv ***
// package for the sequence directional and phase mho element block
// assumes phasors arrive as signed fixed-point re/im pairs in common units
package ndm_pkg;

   // ------------------------------------------------------------
   // number formats and field widths
   // ------------------------------------------------------------
   localparam int CW      = 20;   // phasor component width
   localparam int WW      = 64;   // wide arithmetic width
   localparam int ZONES   = 4;
   localparam int PAIRS   = 3;
   localparam int ANG_FRAC = 15;  // line angle cos/sin are Q15
   localparam int Z_FRAC  = 8;    // impedance and ratio settings are Q8
   localparam logic signed [CW-1:0] SQ3H_Q15 = 20'sh06EDA; // sqrt(3)/2

   // 0.75/0.25 and 1.25/0.25 weights, in quarters
   localparam logic signed [WW-1:0] REV_SET_QTR = 64'sh3;
   localparam logic signed [WW-1:0] FWD_SET_QTR = 64'sh5;
   localparam int QTR_SHIFT = 2;

   // ------------------------------------------------------------
   // element flag vector layout, for contact routing
   // ------------------------------------------------------------
   localparam int FLAG_FWD   = 0;
   localparam int FLAG_REV   = 1;
   localparam int FLAG_INST  = 2;   // 4 zone flags
   localparam int FLAG_DLY   = 6;   // 3 delayed flags, zones 2..4
   localparam int FLAG_PAIR  = 9;   // 12 pair flags, zone*3+pair
   localparam int FLAG_NUM   = 21;
   localparam int ROUTE_W    = 5;
   localparam int DLY_W      = 16;
   localparam logic FLAG_RST = 1'b0;

   typedef enum logic [1:0] {
      LOP_N  = 2'h0,
      LOP_Y  = 2'h1,
      LOP_Y1 = 2'h3,
      LOP_Y2 = 2'h2
   } ndm_lop_type;

   typedef struct packed {
      logic signed [CW-1:0] re;
      logic signed [CW-1:0] im;
   } ndm_cplx_type;

   typedef struct packed {
      ndm_cplx_type va, vb, vc, ia, ib, ic;
   } ndm_phasors_type;

   typedef struct packed {
      logic signed [15:0] lineCos;              // line_angle_setting as cos, Q15
      logic signed [15:0] lineSin;
      logic signed [15:0] fwdImpedanceSetting;  // Q8 ohms
      logic signed [15:0] revImpedanceSetting;
      logic [CW-1:0]      fwdSeqCurrentPickup;  // compared against 3*I2
      logic [CW-1:0]      revSeqCurrentPickup;
      logic [15:0]        seqRatioFactor;       // Q8
   } ndm_dir_set_type;

   typedef struct packed {
      logic              reverse;
      logic [15:0]       reach;                 // Q8 secondary ohms
      logic [DLY_W-1:0]  delay;                 // clock cycles
   } ndm_zone_cfg_type;

   // ------------------------------------------------------------
   // arithmetic helpers
   // ------------------------------------------------------------
   // multiply by a (sq=0) or by a squared (sq=1)
   function automatic ndm_cplx_type rot(ndm_cplx_type x, logic sq);
      logic signed [2*CW-1:0] sr;
      logic signed [2*CW-1:0] si;
      ndm_cplx_type           r;
      sr = (40'(x.re) * 40'(SQ3H_Q15)) >>> ANG_FRAC;
      si = (40'(x.im) * 40'(SQ3H_Q15)) >>> ANG_FRAC;
      r.re = CW'((x.re >>> 1) * -1) + (sq ? CW'(si) : -CW'(si));
      r.im = (sq ? -CW'(sr) : CW'(sr)) - (x.im >>> 1);
      return r;
   endfunction

   // three times the sequence value: b, c rotated by a^2/a (neg) or a/a^2 (pos)
   function automatic ndm_cplx_type seq3(ndm_cplx_type a, ndm_cplx_type b,
                                         ndm_cplx_type c, logic neg);
      ndm_cplx_type rb;
      ndm_cplx_type rc;
      ndm_cplx_type r;
      rb = rot(b, neg);
      rc = rot(c, !neg);
      r.re = a.re + rb.re + rc.re;
      r.im = a.im + rb.im + rc.im;
      return r;
   endfunction

   // Re[v * conj(i * line angle)], scaled back out of Q15
   function automatic logic signed [WW-1:0] dirNum(ndm_cplx_type v, ndm_cplx_type i,
                                                    logic signed [15:0] c,
                                                    logic signed [15:0] s);
      logic signed [WW-1:0] pr;
      logic signed [WW-1:0] pi;
      pr = WW'(v.re) * WW'(i.re) + WW'(v.im) * WW'(i.im);
      pi = WW'(v.im) * WW'(i.re) - WW'(v.re) * WW'(i.im);
      return (pr * WW'(c) + pi * WW'(s)) >>> ANG_FRAC;
   endfunction

   function automatic logic signed [WW-1:0] sq(ndm_cplx_type x);
      return WW'(x.re) * WW'(x.re) + WW'(x.im) * WW'(x.im);
   endfunction

   // max + 3/8 min magnitude estimate; within about 7 percent, avoids a root
   function automatic logic signed [WW-1:0] mag(ndm_cplx_type x);
      logic signed [WW-1:0] ar;
      logic signed [WW-1:0] ai;
      logic signed [WW-1:0] mx;
      logic signed [WW-1:0] mn;
      ar = (x.re < 0) ? -WW'(x.re) : WW'(x.re);
      ai = (x.im < 0) ? -WW'(x.im) : WW'(x.im);
      mx = (ar > ai) ? ar : ai;
      mn = (ar > ai) ? ai : ar;
      return mx + (mn >>> 2) + (mn >>> 3);
   endfunction

endpackage

// *** dv/ndm_front_end.sv ***
// front-end model: hands over one phasor set per update under a one-cycle strobe
// assumes the bench calls send from its own process and owns mclk
`timescale 1ns/100ps
module ndm_front_end
   import ndm_pkg::*;
(
   input  wire logic        mclk,
   output logic             phUpdValid,
   output ndm_phasors_type  phasors
);
   // ----------------------------------------
   // update strobe
   // ----------------------------------------
   initial begin
      phUpdValid = 1'b0;
      phasors    = '0;
   end

   // va on the real axis, ia on the imaginary axis, b and c phases at zero
   task automatic send(input int vaRe, input int iaIm, input int gap);
      repeat (gap) @(negedge mclk);
      phasors       = '0;
      phasors.va.re = CW'(vaRe);
      phasors.ia.im = CW'(iaIm);
      phUpdValid    = 1'b1;
      @(negedge mclk);
      phUpdValid    = 1'b0;
      // the set is only valid under the strobe, so scramble it afterwards
      phasors       = ~phasors;
   endtask
endmodule // ndm_front_end

// *** dv/neg_seq_directional_phase_mho_bench.sv ***
// self-checking bench for the sequence directional and phase mho block
// assumes ndm_pkg, the front-end model and one 100 MHz clock
`timescale 1ns/100ps
module neg_seq_directional_phase_mho_bench
   import ndm_pkg::*;
;
   // ----------------------------------------
   // signals and reference model
   // ----------------------------------------
   logic                    mclk, sys_rst, potentialLoss, phUpdValid;
   ndm_phasors_type         phasors;
   ndm_dir_set_type         dirSet;
   ndm_zone_cfg_type [3:0]  zoneCfg;
   logic [2:0]              phaseZoneCount, zoneDelayedFlag;
   ndm_lop_type             potentialLossEnable;
   logic [ROUTE_W-1:0]      contactSevenSrc, contactEightSrc;
   logic                    fwdDirFlag, revDirFlag, contactSeven, contactEight, expF, expR;
   logic [3:0]              zoneInstFlag, expZ;
   logic [11:0]             pairZoneFlag, expP;
   logic [22:0]             allOut;
   logic [2:0]              dlyExp [4] = '{3'h0, 3'h4, 3'h5, 3'h7};
   int                      pts [6] = '{200, 600, 3000, -60, 60, 40};
   int                      errors, n_compared, seed = 3, m;

   assign allOut = {fwdDirFlag, revDirFlag, zoneInstFlag, zoneDelayedFlag, pairZoneFlag,
                    contactSeven, contactEight};

   ndm_top uut (.mclk, .sys_rst, .phUpdValid, .phasors, .dirSet, .zoneCfg, .phaseZoneCount,
      .potentialLossEnable, .potentialLoss, .contactSevenSrc, .contactEightSrc, .fwdDirFlag,
      .revDirFlag, .zoneInstFlag, .zoneDelayedFlag, .pairZoneFlag, .contactSeven,
      .contactEight);
   ndm_front_end fe (.mclk, .phUpdValid, .phasors);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   initial begin
      #200000;   // hang guard
      errors++;
      conclude();
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // va = -1800 real and ia = j*m keep the angle and magnitude terms exact
   task automatic model(input int mm);
      real zc, zm, ft, rt, s;
      bit  okA, hit;
      int  am;
      am  = (mm < 0) ? -mm : mm;
      zc  = 1800.0 / mm;
      zm  = 1800.0 / am;
      ft  = $itor(dirSet.fwdImpedanceSetting) / 256.0;
      rt  = $itor(dirSet.revImpedanceSetting) / 256.0;
      if (ft > 0) ft = 1.25 * ft - 0.25 * zm;
      if (rt > 0) rt = 0.75 * rt + 0.25 * zm;
      okA = am > dirSet.seqRatioFactor * am / 256.0;
      expF = (potentialLoss && potentialLossEnable inside {LOP_Y, LOP_Y2})
             || (okA && am > dirSet.fwdSeqCurrentPickup && zc < ft);
      expR = okA && am > dirSet.revSeqCurrentPickup && zc > rt;
      for (int z = 0; z < 4; z++) begin
         s   = zoneCfg[z].reverse ? -zc : zc;
         hit = z < phaseZoneCount && (zoneCfg[z].reverse ? expR : expF)
               && s > 0 && s < zoneCfg[z].reach / 256.0;
         expZ[z] = hit;
         expP[z*3 +: 3] = {hit, 1'b0, hit};
      end
   endtask

   function automatic logic routeFlag(input logic [ROUTE_W-1:0] s);
      logic [FLAG_NUM-1:0] v;
      v = {expP, 3'h0, expZ, expR, expF};
      return (s < FLAG_NUM) ? v[s] : 1'b0;
   endfunction

   task automatic update(input int mm, input int gap);
      model(mm);
      fe.send(-1800, mm, gap);
      check(fwdDirFlag, expF);
      check(revDirFlag, expR);
      check(zoneInstFlag, expZ);
      check(pairZoneFlag, expP);
      @(negedge mclk);
      check(contactSeven, routeFlag(contactSevenSrc));
      check(contactEight, routeFlag(contactEightSrc));
   endtask

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      sys_rst = 1'b1;
      potentialLoss = 1'b0;
      potentialLossEnable = LOP_N;
      phaseZoneCount = 3'h0;
      contactSevenSrc = 5'h00;
      contactEightSrc = 5'h01;
      // line angle of ninety degrees
      dirSet = {16'sh0000, 16'sh7FFF, 16'sh00C5, 16'sh0573, 20'h00032, 20'h00046, 16'h0012};
      zoneCfg = {{1'b0, 16'h0100, 16'h0001}, {1'b0, 16'h0100, 16'h0003},
                 {1'b0, 16'h0100, 16'h0002}, {1'b0, 16'h0100, 16'h0002}};
      repeat (4) @(negedge mclk);
      check(allOut, 32'h0);
      sys_rst = 1'b0;
      @(negedge mclk);
      check(allOut, 32'h0);
      // directed points sit well clear of every threshold
      foreach (pts[j]) update(pts[j], 1);
      dirSet.seqRatioFactor = 16'h0140;
      update(200, 0);
      dirSet.seqRatioFactor = 16'h0012;
      contactEightSrc = 5'h1F;
      potentialLoss = 1'b1;
      for (int k = 0; k < 4; k++) begin
         potentialLossEnable = ndm_lop_type'(k);
         update(1000, 2);
      end
      potentialLoss = 1'b0;
      contactEightSrc = 5'h01;
      for (int k = 0; k < 40; k++) begin
         m = 80 + $unsigned($random(seed)) % 3900;
         if ((m > 290 && m < 380) || (m > 2100 && m < 2600)) m = 1000;
         if ($random(seed) & 1) m = -m;
         update(m, $unsigned($random(seed)) % 3);
      end
      contactSevenSrc = 5'h0B;
      contactEightSrc = 5'h05;
      for (int k = 0; k <= 4; k++) begin
         phaseZoneCount = 3'(k);
         update(3000, 0);
      end
      update(600, 0);
      check(zoneDelayedFlag, 3'h0);
      update(3000, 0);
      foreach (dlyExp[j]) begin
         check(zoneDelayedFlag, dlyExp[j]);
         @(negedge mclk);
      end
      // a non-positive setting is taken as the threshold itself
      dirSet.revImpedanceSetting = 16'shFF00;
      zoneCfg[2].reverse = 1'b1;
      update(-3000, 1);
      sys_rst = 1'b1;
      #1;
      check(allOut, 32'h0);
      @(negedge mclk);
      sys_rst = 1'b0;
      conclude();
   end
endmodule // neg_seq_directional_phase_mho_bench
